/* core/pccr_regs.svh */
// register offsets, field positions and reset values of the clock configuration bank
// assumes inclusion by bare name from core/ files
`ifndef PCCR_REGS_SVH
`define PCCR_REGS_SVH
`define PCCR_DEV_ADDR 7'h69
`define PCCR_OFF_OUTPUT_ENABLE 8'h09
`define PCCR_OFF_BANK1 8'h0C
`define PCCR_OFF_OSC_GAIN 8'h12
`define PCCR_OFF_LOAD_CAP 8'h13
`define PCCR_OFF_PUMP_FB_HIGH 8'h40
`define PCCR_OFF_FB_BASE_LOW 8'h41
`define PCCR_OFF_ODD_PREDIV 8'h42
`define PCCR_OFF_XPOINT_A 8'h44
`define PCCR_OFF_XPOINT_B 8'h45
`define PCCR_OFF_XPOINT_C 8'h46
`define PCCR_OFF_BANK2 8'h47
`define PCCR_RST_OUTPUT_ENABLE 8'h00
`define PCCR_RST_BANK 8'h08
`define PCCR_RST_OSC_GAIN 8'h20
`define PCCR_RST_LOAD_CAP 8'h00
`define PCCR_RST_PUMP_FB_HIGH 8'hC0
`define PCCR_RST_FB_BASE_LOW 8'h00
`define PCCR_RST_ODD_PREDIV 8'h00
`define PCCR_RST_XPOINT 8'h00
`define PCCR_RST_XPOINT_C 8'h3F
`define PCCR_MASK_OUTPUT_ENABLE 8'h3F
`define PCCR_MASK_OSC_GAIN 8'h18
`define PCCR_FIX_OSC_GAIN 8'h20
`define PCCR_MASK_PUMP_FB_HIGH 8'h1F
`define PCCR_FIX_PUMP_FB_HIGH 8'hC0
`define PCCR_MASK_XPOINT_C 8'hC0
`define PCCR_FIX_XPOINT_C 8'h3F
`define PCCR_GAIN_MSB 4
`define PCCR_GAIN_LSB 3
`define PCCR_BANK_SRC_BIT 7
`endif

/* core/pccr_pkg.sv */
// types of the clock configuration bank
// assumes nothing of its surroundings
package pccr_pkg;
	typedef enum logic [6:0] {
		PCCR_IDLE = 7'b000_0001,
		PCCR_DEVADDR = 7'b000_0010,
		PCCR_ACK = 7'b000_0100,
		PCCR_REGADDR = 7'b000_1000,
		PCCR_WDATA = 7'b001_0000,
		PCCR_RDATA = 7'b010_0000,
		PCCR_RACK = 7'b100_0000
	} pccr_state_t;
endpackage : pccr_pkg

/* core/pccr_wr_if.sv */
// write/read carrier between the serial slave and the register store
// assumes one clock on both sides
`timescale 1ns/1ps
`default_nettype none
interface pccr_wr_if;
	logic we;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	modport slave_side (output we, output addr, output wdata, input rdata);
	modport store_side (input we, input addr, input wdata, output rdata);
endinterface : pccr_wr_if
`default_nettype wire

/* core/pccr_store.sv */
// register store of the clock configuration bank
// assumes writes arrive one cycle pulse at a time from the serial slave
`timescale 1ns/1ps
`default_nettype none
`include "pccr_regs.svh"
module pccr_store (
	input wire logic clk,
	input wire logic rst,
	pccr_wr_if.store_side bus,
	output logic [7:0] output_enable,
	output logic [7:0] bank1_source_divisor,
	output logic [7:0] oscillator_gain,
	output logic [7:0] load_capacitance,
	output logic [7:0] pump_and_feedback_high,
	output logic [7:0] feedback_base_low,
	output logic [7:0] odd_bit_and_predivider,
	output logic [7:0] crosspoint_select_a,
	output logic [7:0] crosspoint_select_b,
	output logic [7:0] crosspoint_select_c,
	output logic [7:0] bank2_source_divisor
);
	// register hits
	wire hit_oe = bus.we && bus.addr == `PCCR_OFF_OUTPUT_ENABLE;
	wire hit_b1 = bus.we && bus.addr == `PCCR_OFF_BANK1;
	wire hit_gain = bus.we && bus.addr == `PCCR_OFF_OSC_GAIN;
	wire hit_cap = bus.we && bus.addr == `PCCR_OFF_LOAD_CAP;
	wire hit_pump = bus.we && bus.addr == `PCCR_OFF_PUMP_FB_HIGH;
	wire hit_fbl = bus.we && bus.addr == `PCCR_OFF_FB_BASE_LOW;
	wire hit_odd = bus.we && bus.addr == `PCCR_OFF_ODD_PREDIV;
	wire hit_xa = bus.we && bus.addr == `PCCR_OFF_XPOINT_A;
	wire hit_xb = bus.we && bus.addr == `PCCR_OFF_XPOINT_B;
	wire hit_xc = bus.we && bus.addr == `PCCR_OFF_XPOINT_C;
	wire hit_b2 = bus.we && bus.addr == `PCCR_OFF_BANK2;

	// reset gives the blank defaults; writes are volatile
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			output_enable <= `PCCR_RST_OUTPUT_ENABLE;
			bank1_source_divisor <= `PCCR_RST_BANK;
			oscillator_gain <= `PCCR_RST_OSC_GAIN;
			load_capacitance <= `PCCR_RST_LOAD_CAP;
			pump_and_feedback_high <= `PCCR_RST_PUMP_FB_HIGH;
			feedback_base_low <= `PCCR_RST_FB_BASE_LOW;
			odd_bit_and_predivider <= `PCCR_RST_ODD_PREDIV;
			crosspoint_select_a <= `PCCR_RST_XPOINT;
			crosspoint_select_b <= `PCCR_RST_XPOINT;
			crosspoint_select_c <= `PCCR_RST_XPOINT_C;
			bank2_source_divisor <= `PCCR_RST_BANK;
		end
		else
		begin
			if (hit_oe)
				output_enable <= bus.wdata & `PCCR_MASK_OUTPUT_ENABLE;
			if (hit_b1)
				bank1_source_divisor <= bus.wdata;
			if (hit_gain)
				oscillator_gain <= (bus.wdata & `PCCR_MASK_OSC_GAIN) | `PCCR_FIX_OSC_GAIN;
			if (hit_cap)
				load_capacitance <= bus.wdata;
			if (hit_pump)
				pump_and_feedback_high <= (bus.wdata & `PCCR_MASK_PUMP_FB_HIGH) | `PCCR_FIX_PUMP_FB_HIGH;
			if (hit_fbl)
				feedback_base_low <= bus.wdata;
			if (hit_odd)
				odd_bit_and_predivider <= bus.wdata;
			if (hit_xa)
				crosspoint_select_a <= bus.wdata;
			if (hit_xb)
				crosspoint_select_b <= bus.wdata;
			if (hit_xc)
				crosspoint_select_c <= (bus.wdata & `PCCR_MASK_XPOINT_C) | `PCCR_FIX_XPOINT_C;
			if (hit_b2)
				bank2_source_divisor <= bus.wdata;
		end
	end

	// read mux; unmapped reads return zero
	always_comb
	begin
		case (bus.addr)
			`PCCR_OFF_OUTPUT_ENABLE: bus.rdata = output_enable;
			`PCCR_OFF_BANK1: bus.rdata = bank1_source_divisor;
			`PCCR_OFF_OSC_GAIN: bus.rdata = oscillator_gain;
			`PCCR_OFF_LOAD_CAP: bus.rdata = load_capacitance;
			`PCCR_OFF_PUMP_FB_HIGH: bus.rdata = pump_and_feedback_high;
			`PCCR_OFF_FB_BASE_LOW: bus.rdata = feedback_base_low;
			`PCCR_OFF_ODD_PREDIV: bus.rdata = odd_bit_and_predivider;
			`PCCR_OFF_XPOINT_A: bus.rdata = crosspoint_select_a;
			`PCCR_OFF_XPOINT_B: bus.rdata = crosspoint_select_b;
			`PCCR_OFF_XPOINT_C: bus.rdata = crosspoint_select_c;
			`PCCR_OFF_BANK2: bus.rdata = bank2_source_divisor;
			default: bus.rdata = 8'h00;
		endcase
	end
endmodule : pccr_store
`default_nettype wire

/* core/pccr_top.sv */
// clock configuration bank: serial slave, register store and field decode
// Operation
// - outputs from pll, divided ref, or ref
// - six outputs each pick one of seven
// - two /2, /3, /4, two programmable divisors
// - seventh source passes reference straight through
// - blank state: defaults, outputs off, oscillator on
// - slave answers at seven-bit address 69h
// - eight-bit register address, eight data bits
// - writes volatile; reset restores defaults
// - oscillator gain in bits 4:3 of 12h
// - load capacitance code in register 13h
// - load capacitance code defaults to zero
// - 44h-46h three-bit per-output source selects
// - 0ch: bank 1 source and divisor
// - 47h: bank 2 source and divisor
// - 42h: feedback odd bit and predivider
// - 40h: fixed 110, pump, feedback high bits
// assumes serial clock and data pins are asynchronous to clk and are much slower than it
`timescale 1ns/1ps
`default_nettype none
`include "pccr_regs.svh"
module pccr_top (
	input wire logic clk,
	input wire logic rst,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	output logic osc_enable,
	output logic [5:0] output_enable_bits,
	output logic bank1_source_select,
	output logic [6:0] bank1_divisor,
	output logic bank2_source_select,
	output logic [6:0] bank2_divisor,
	output logic [1:0] osc_gain_setting,
	output logic [7:0] load_cap_code,
	output logic [2:0] pump_setting,
	output logic [9:0] feedback_base_count,
	output logic feedback_odd_bit,
	output logic [6:0] predivider,
	output logic [17:0] output_source_select
);
	// three-stage input sync; a change counts when stages two and three agree
	logic [2:0] scl_sync;
	logic [2:0] sda_sync;
	logic scl_f;
	logic sda_f;
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			scl_sync <= 3'h7;
			sda_sync <= 3'h7;
		end
		else
		begin
			scl_sync <= {scl_sync[1:0], scl_in};
			sda_sync <= {sda_sync[1:0], sda_in};
		end
	end

	// filtered levels hold until stages two and three agree
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			scl_f <= 1'b1;
			sda_f <= 1'b1;
		end
		else
		begin
			if (scl_sync[1] == scl_sync[2])
				scl_f <= scl_sync[2];
			if (sda_sync[1] == sda_sync[2])
				sda_f <= sda_sync[2];
		end
	end

	// previous filtered levels for edge and condition detection
	logic scl_q;
	logic sda_q;
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end
		else
		begin
			scl_q <= scl_f;
			sda_q <= sda_f;
		end
	end

	// bus events
	wire scl_rise = scl_f && !scl_q;
	wire scl_fall = !scl_f && scl_q;
	wire start_cond = scl_f && scl_q && sda_q && !sda_f;
	wire stop_cond = scl_f && scl_q && !sda_q && sda_f;

	pccr_wr_if wr ();

	pccr_pkg::pccr_state_t state;
	pccr_pkg::pccr_state_t next_state;
	logic [7:0] shift;
	logic [3:0] bit_cnt;
	logic is_read;
	logic addr_phase;
	logic [7:0] reg_addr;
	logic [7:0] tx_byte;
	logic drive_low;
	logic acked_byte;

	// byte completion and address match
	wire byte_done = scl_rise && bit_cnt == 4'h7;
	wire [7:0] shift_next = {shift[6:0], sda_f};
	wire addr_match = shift_next[7:1] == `PCCR_DEV_ADDR;
	wire wr_fire = state == pccr_pkg::PCCR_WDATA && byte_done;

	// one-hot serial slave sequence
	always_comb
	begin
		next_state = state;
		case (state)
			pccr_pkg::PCCR_IDLE: next_state = state;
			pccr_pkg::PCCR_DEVADDR:
				if (byte_done)
					next_state = addr_match ? pccr_pkg::PCCR_ACK : pccr_pkg::PCCR_IDLE;
			pccr_pkg::PCCR_ACK:
				if (scl_fall && acked_byte)
					next_state = is_read ? pccr_pkg::PCCR_RDATA
						: (addr_phase ? pccr_pkg::PCCR_REGADDR : pccr_pkg::PCCR_WDATA);
			pccr_pkg::PCCR_REGADDR:
				if (byte_done)
					next_state = pccr_pkg::PCCR_ACK;
			pccr_pkg::PCCR_WDATA:
				if (byte_done)
					next_state = pccr_pkg::PCCR_ACK;
			pccr_pkg::PCCR_RDATA:
				if (scl_fall && bit_cnt == 4'h8)
					next_state = pccr_pkg::PCCR_RACK;
			pccr_pkg::PCCR_RACK:
				if (scl_rise)
					next_state = sda_f ? pccr_pkg::PCCR_IDLE : pccr_pkg::PCCR_RDATA;
			default: next_state = pccr_pkg::PCCR_IDLE;
		endcase
		if (start_cond)
			next_state = pccr_pkg::PCCR_DEVADDR;
		else if (stop_cond)
			next_state = pccr_pkg::PCCR_IDLE;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			state <= pccr_pkg::PCCR_IDLE;
		else
			state <= next_state;
	end

	// bit counter, shifter and per-transfer flags
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			shift <= 8'h00;
			bit_cnt <= 4'h0;
			is_read <= 1'b0;
			addr_phase <= 1'b0;
			reg_addr <= 8'h00;
			acked_byte <= 1'b0;
		end
		else if (start_cond)
		begin
			bit_cnt <= 4'h0;
			acked_byte <= 1'b0;
		end
		else
		begin
			if (scl_rise && state != pccr_pkg::PCCR_ACK && state != pccr_pkg::PCCR_RACK)
			begin
				shift <= shift_next;
				bit_cnt <= bit_cnt + 4'h1;
			end
			if (state == pccr_pkg::PCCR_ACK && scl_rise)
				acked_byte <= 1'b1; // ack clock seen; leave on its falling edge
			if (state != pccr_pkg::PCCR_ACK)
				acked_byte <= 1'b0;
			if (state == pccr_pkg::PCCR_ACK && scl_fall && acked_byte)
				bit_cnt <= 4'h0;
			if (state == pccr_pkg::PCCR_RACK && scl_rise)
				bit_cnt <= 4'h0;
			if (state == pccr_pkg::PCCR_DEVADDR && byte_done)
			begin
				is_read <= shift_next[0];
				addr_phase <= !shift_next[0];
			end
			if (state == pccr_pkg::PCCR_REGADDR && byte_done)
			begin
				reg_addr <= shift_next;
				addr_phase <= 1'b0;
			end
			if (wr_fire || (state == pccr_pkg::PCCR_RACK && scl_rise && !sda_f))
				reg_addr <= reg_addr + 8'h01; // auto-increment for bursts
		end
	end

	// store access: write strobes on the eighth data bit, before the ack clock
	assign wr.we = wr_fire;
	assign wr.addr = reg_addr;
	assign wr.wdata = shift_next;

	// read byte loaded at each read-byte start; drive low for ack or zero bit
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			tx_byte <= 8'h00;
			drive_low <= 1'b0;
		end
		else
		begin
			if (state == pccr_pkg::PCCR_ACK && scl_fall && acked_byte && is_read)
				tx_byte <= wr.rdata;
			else if (state == pccr_pkg::PCCR_RACK && scl_rise && !sda_f)
				tx_byte <= wr.rdata;
			else if (state == pccr_pkg::PCCR_RDATA && scl_fall && bit_cnt != 4'h0)
				tx_byte <= {tx_byte[6:0], 1'b0};
			// ack pull waits for the scl fall after the eighth bit; pulling with scl high fakes a start
			if (state == pccr_pkg::PCCR_ACK && !(scl_fall && acked_byte))
				drive_low <= drive_low || scl_fall;
			else if (next_state == pccr_pkg::PCCR_RDATA)
				drive_low <= state == pccr_pkg::PCCR_RDATA && scl_fall && bit_cnt != 4'h0
					? !tx_byte[6] : (state == pccr_pkg::PCCR_RDATA ? drive_low : !wr.rdata[7]);
			else
				drive_low <= 1'b0;
		end
	end

	// open-drain data pin: only ever pulls low
	assign sda_out = 1'b0;
	assign sda_oe = drive_low;

	logic [7:0] output_enable;
	logic [7:0] bank1_source_divisor;
	logic [7:0] oscillator_gain;
	logic [7:0] load_capacitance;
	logic [7:0] pump_and_feedback_high;
	logic [7:0] feedback_base_low;
	logic [7:0] odd_bit_and_predivider;
	logic [7:0] crosspoint_select_a;
	logic [7:0] crosspoint_select_b;
	logic [7:0] crosspoint_select_c;
	logic [7:0] bank2_source_divisor;

	pccr_store u_store (
		.clk(clk),
		.rst(rst),
		.bus(wr.store_side),
		.output_enable(output_enable),
		.bank1_source_divisor(bank1_source_divisor),
		.oscillator_gain(oscillator_gain),
		.load_capacitance(load_capacitance),
		.pump_and_feedback_high(pump_and_feedback_high),
		.feedback_base_low(feedback_base_low),
		.odd_bit_and_predivider(odd_bit_and_predivider),
		.crosspoint_select_a(crosspoint_select_a),
		.crosspoint_select_b(crosspoint_select_b),
		.crosspoint_select_c(crosspoint_select_c),
		.bank2_source_divisor(bank2_source_divisor)
	);

	// oscillator never stopped by configuration
	assign osc_enable = 1'b1;

	// field decode into the analog clock path; bank sources pick vco or reference
	assign output_enable_bits = output_enable[5:0];
	assign bank1_source_select = bank1_source_divisor[`PCCR_BANK_SRC_BIT];
	assign bank1_divisor = bank1_source_divisor[6:0];
	assign bank2_source_select = bank2_source_divisor[`PCCR_BANK_SRC_BIT];
	assign bank2_divisor = bank2_source_divisor[6:0];
	assign osc_gain_setting = oscillator_gain[`PCCR_GAIN_MSB:`PCCR_GAIN_LSB];
	assign load_cap_code = load_capacitance;
	assign pump_setting = pump_and_feedback_high[4:2];
	assign feedback_base_count = {pump_and_feedback_high[1:0], feedback_base_low};
	assign feedback_odd_bit = odd_bit_and_predivider[7];
	assign predivider = odd_bit_and_predivider[6:0];
	// output one in bits 17:15 down to output six in 2:0; code 000 is the reference bypass
	assign output_source_select = {crosspoint_select_a, crosspoint_select_b, crosspoint_select_c[7:6]};
endmodule : pccr_top
`default_nettype wire

/* tb/pccr_top_monitor.sv */
// assertions on the clock configuration bank pins
// assumes a bind onto pccr_top, one clock and one reset
`timescale 1ns/1ps
`default_nettype none
module pccr_top_monitor (
	input wire logic clk,
	input wire logic rst,
	input wire logic scl_in,
	input wire logic sda_oe,
	input wire logic osc_enable,
	input wire logic [5:0] output_enable_bits,
	input wire logic bank1_source_select,
	input wire logic [6:0] bank1_divisor,
	input wire logic bank2_source_select,
	input wire logic [6:0] bank2_divisor,
	input wire logic [1:0] osc_gain_setting,
	input wire logic [7:0] load_cap_code,
	input wire logic [9:0] feedback_base_count,
	input wire logic feedback_odd_bit,
	input wire logic [6:0] predivider,
	input wire logic [17:0] output_source_select
);
	default clocking mcb @(posedge clk);
	endclocking
	default disable iff (rst);
	// blank state seen on the first edge after each reset
	AST_OUTPUTS_OFF: assert property ($fell(rst) |-> output_enable_bits == 6'h00
		&& output_source_select == 18'h0_0000) else $error("outputs not off after reset");
	AST_BANK_DEFAULT: assert property ($fell(rst) |-> {bank1_source_select, bank1_divisor} == 8'h08
		&& {bank2_source_select, bank2_divisor} == 8'h08) else $error("bank default wrong");
	AST_CAP_DEFAULT: assert property ($fell(rst) |-> load_cap_code == 8'h00 && osc_gain_setting == 2'b00)
		else $error("cap or gain default wrong");
	AST_PLL_DEFAULT: assert property ($fell(rst) |-> feedback_base_count == 10'h000
		&& {feedback_odd_bit, predivider} == 8'h00) else $error("pll default wrong");
	// oscillator never stops, blank or programmed
	AST_OSC_RUNS: assert property (osc_enable == 1'b1)
		else $error("oscillator stopped");
	// data line only moves while the serial clock is low
	AST_SDA_IN_LOW: assert property ($changed(sda_oe) |-> !scl_in)
		else $error("data line moved with scl high");
	// a committed byte lands while the data bit clock is high
	AST_WRITE_IN_HIGH: assert property ($changed({output_enable_bits, load_cap_code, output_source_select})
		|-> scl_in) else $error("field changed with scl low");
	// the pull never sticks past 400 clocks
	AST_SDA_RELEASED: assert property ($rose(sda_oe) |-> ##[1:400] !sda_oe)
		else $error("data line held too long");
endmodule : pccr_top_monitor
`default_nettype wire

/* tb/pccr_i2c_host_model.sv */
// serial host master for the clock configuration bank
// assumes a pull-up on the data line; scl stands still between frames
`timescale 1ns/1ps
`default_nettype none
module pccr_i2c_host_model #(
	parameter int HALF = 10
) (
	input wire logic clk,
	input wire logic sda_line,
	output logic scl,
	output logic sda_low
);
	// both lines released at time zero
	initial
	begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	// wait n clocks, then act just after the edge
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick
	// one bit slot; data moves well clear of the scl fall
	task automatic slot(input logic b, output logic s);
		tick(4);
		sda_low = !b;
		tick(HALF - 4);
		scl = 1'b1;
		tick(HALF);
		s = sda_line;
		scl = 1'b0;
	endtask : slot
	// st=1: start or repeated start; st=0: stop
	task automatic cond(input logic st);
		tick(4);
		sda_low = !st;
		tick(HALF - 4);
		scl = 1'b1;
		tick(HALF);
		sda_low = st;
		tick(HALF);
		scl = !st;
	endtask : cond
	// eight bits msb first, then the ack slot released
	task automatic send(input logic [7:0] v, output logic nack);
		logic s;
		for (int i = 7; i >= 0; i--)
			slot(v[i], s);
		slot(1'b1, nack);
	endtask : send
	// register address first, the bank steps the address per byte
	task automatic wr(input logic [6:0] dev, input logic [7:0] a, input logic [7:0] dq[$], output logic nack);
		logic n;
		cond(1'b1);
		send({dev, 1'b0}, nack);
		send(a, n);
		nack = nack | n;
		foreach (dq[i])
		begin
			send(dq[i], n);
			nack = nack | n;
		end
		cond(1'b0);
	endtask : wr
	// set the address, turn round, take one byte and refuse more
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		logic n;
		cond(1'b1);
		send({7'h69, 1'b0}, n);
		send(a, n);
		cond(1'b1);
		send({7'h69, 1'b1}, n);
		for (int i = 7; i >= 0; i--)
			slot(1'b1, v[i]);
		slot(1'b1, n);
		cond(1'b0);
	endtask : rd
endmodule : pccr_i2c_host_model
`default_nettype wire

/* tb/pccr_top_tb.sv */
// self-checking bench for the clock configuration bank
// assumes the host model owns the serial pins; data line pulled up
`timescale 1ns/1ps
`default_nettype none
module pccr_top_tb;
	logic clk, rst, mst_low, nk, sda_out, sda_oe, osc_enable, bank1_source_select, bank2_source_select;
	logic feedback_odd_bit;
	logic [5:0] output_enable_bits;
	logic [6:0] bank1_divisor, bank2_divisor, predivider;
	logic [1:0] osc_gain_setting;
	logic [7:0] load_cap_code;
	logic [2:0] pump_setting;
	logic [9:0] feedback_base_count;
	logic [17:0] output_source_select;
	wire scl_in;
	wire sda_in = !(mst_low || (sda_oe && !sda_out)); // low if anyone sinks it
	logic [7:0] mdl [256];
	logic [7:0] offs [12] = '{8'h09, 8'h0C, 8'h12, 8'h13, 8'h40, 8'h41, 8'h42, 8'h44, 8'h45, 8'h46, 8'h47, 8'h50};
	string nm_q[$];
	logic [31:0] exp_q[$];
	logic [31:0] seen;
	event seen_ev;
	int fails = 0;
	int comparisons = 0;
	pccr_top pccr_top_inst (.clk, .rst, .scl_in, .sda_in, .sda_out, .sda_oe, .osc_enable, .output_enable_bits,
		.bank1_source_select, .bank1_divisor, .bank2_source_select, .bank2_divisor, .osc_gain_setting,
		.load_cap_code, .pump_setting, .feedback_base_count, .feedback_odd_bit, .predivider, .output_source_select);
	pccr_i2c_host_model pccr_i2c_host_model_inst (.clk, .sda_line(sda_in), .scl(scl_in), .sda_low(mst_low));
	// value the bank must hold after data d lands at address a
	function automatic logic [7:0] held(input logic [7:0] a, input logic [7:0] d);
		case (a)
			8'h09: return d & 8'h3F;
			8'h12: return (d & 8'h18) | 8'h20;
			8'h40: return (d & 8'h1F) | 8'hC0;
			8'h46: return (d & 8'hC0) | 8'h3F;
			8'h50: return 8'h00;
			default: return d;
		endcase
	endfunction : held
	task automatic check(input string nm, input logic [31:0] sv, input logic [31:0] ev);
		comparisons++;
		if (sv !== ev)
		begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", nm, ev, sv);
		end
	endtask : check
	// queue the expectation, then announce the result to the watcher
	task automatic note(input string nm, input logic [31:0] sv, input logic [31:0] ev);
		nm_q.push_back(nm);
		exp_q.push_back(ev);
		seen = sv;
		->seen_ev;
		#0.01;
	endtask : note
	// watcher: oldest expectation against each result
	initial
		forever
		begin
			@(seen_ev);
			check(nm_q.pop_front(), seen, exp_q.pop_front());
		end
	task automatic reset_image();
		foreach (offs[i])
			mdl[offs[i]] = held(offs[i], 8'h00);
		mdl[8'h0C] = 8'h08;
		mdl[8'h47] = 8'h08;
	endtask : reset_image
	// every field pin against the register image
	task automatic check_ports();
		note("enables", 32'(output_enable_bits), 32'(mdl[8'h09][5:0]));
		note("bank1", 32'({bank1_source_select, bank1_divisor}), 32'(mdl[8'h0C]));
		note("bank2", 32'({bank2_source_select, bank2_divisor}), 32'(mdl[8'h47]));
		note("gain", 32'(osc_gain_setting), 32'(mdl[8'h12][4:3]));
		note("cap", 32'(load_cap_code), 32'(mdl[8'h13]));
		note("pump", 32'(pump_setting), 32'(mdl[8'h40][4:2]));
		note("fb", 32'(feedback_base_count), 32'({mdl[8'h40][1:0], mdl[8'h41]}));
		note("prediv", 32'({feedback_odd_bit, predivider}), 32'(mdl[8'h42]));
		note("xsel", 32'(output_source_select), 32'({mdl[8'h44], mdl[8'h45], mdl[8'h46][7:6]}));
		note("osc", 32'(osc_enable), 32'h1);
	endtask : check_ports
	task automatic check_reads();
		logic [7:0] v;
		foreach (offs[i])
		begin
			pccr_i2c_host_model_inst.rd(offs[i], v);
			note("readback", 32'(v), 32'(mdl[offs[i]]));
		end
	endtask : check_reads
	// write a burst; a foreign device address must go unanswered
	task automatic put(input logic [6:0] dev, input logic [7:0] a, input logic [7:0] dq[$]);
		logic n;
		pccr_i2c_host_model_inst.wr(dev, a, dq, n);
		note("ack", 32'(n), 32'(dev != 7'h69));
		if (dev == 7'h69)
			foreach (dq[i])
				mdl[a + 8'(i)] = held(a + 8'(i), dq[i]);
	endtask : put
	task automatic complete_run();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : complete_run
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// hang guard
	initial
	begin
		repeat (100000) @(posedge clk);
		fails++;
		complete_run();
	end
	initial
	begin
		rst = 1'b1;
		void'($urandom(32'h3415));
		repeat (6) @(posedge clk);
		#1 rst = 1'b0;
		repeat (4) @(posedge clk);
		reset_image();
		check_ports();
		check_reads();
		$display("test defaults done");
		foreach (offs[i])
			put(7'h69, offs[i], {8'($urandom)});
		check_ports();
		check_reads();
		$display("test random writes done");
		for (int g = 0; g < 4; g++)
		begin
			put(7'h69, 8'h12, {8'h20 | 8'(g << 3)});
			check_ports();
		end
		// bursts cross the crosspoint and pll registers; all-ones hits fixed bits
		put(7'h69, 8'h44, {8'($urandom), 8'($urandom), 8'($urandom), 8'($urandom)});
		put(7'h69, 8'h40, {8'hFF, 8'hFF, 8'hFF});
		put(7'h68, 8'h13, {8'hA5});
		check_ports();
		$display("test bursts done");
		// reset mid-frame drops the write; image must be rewritten after
		fork
			pccr_i2c_host_model_inst.wr(7'h69, 8'h13, {8'h5A}, nk);
			begin
				repeat (300) @(posedge clk);
				#1 rst = 1'b1;
				for (int k = 0; k < 40 && scl_in; k++)
					@(posedge clk);
				#1 rst = 1'b0;
			end
		join
		reset_image();
		check_ports();
		put(7'h69, 8'h13, {8'h5A});
		check_ports();
		$display("test mid-frame reset done");
		complete_run();
	end
endmodule : pccr_top_tb
bind pccr_top pccr_top_monitor pccr_top_monitor_inst (.clk, .rst, .scl_in, .sda_oe, .osc_enable,
	.output_enable_bits, .bank1_source_select, .bank1_divisor, .bank2_source_select, .bank2_divisor,
	.osc_gain_setting, .load_cap_code, .feedback_base_count, .feedback_odd_bit, .predivider, .output_source_select);
`default_nettype wire
